// File: src/cdgc_pkg.sv
package cdgc_pkg;

	// bus geometry
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 8;
	localparam int NUM_SOCK = 2;

	// register byte offsets; socket b sits one stride above socket a
	localparam logic [11:0] SOCK_STRIDE    = 12'h040;
	localparam logic [11:0] CSC_OFFSET     = 12'h804;
	localparam logic [11:0] CSC_CFG_OFFSET = 12'h805;
	localparam logic [11:0] CDGC_OFFSET    = 12'h816;
	localparam logic [11:0] GCTL_OFFSET    = 12'h81E;

	// card detect and general control field positions
	localparam int CDGC_SENSE2_BIT   = 7;
	localparam int CDGC_SENSE1_BIT   = 6;
	localparam int CDGC_SOFT_IRQ_BIT = 5;
	localparam int CDGC_WAKE_EN_BIT  = 4;
	localparam int CDGC_REG_RST_BIT  = 1;

	// neighbouring register fields used here
	localparam int CSC_DETECT_BIT     = 3;
	localparam int CFG_DETECT_EN_BIT  = 3;
	localparam int GCTL_CLR_MODE_BIT  = 2;

	// values after reset
	localparam logic       WAKE_EN_RST    = 1'b0;
	localparam logic       REG_RST_EN_RST = 1'b0;
	localparam logic       DETECT_EN_RST  = 1'b0;
	localparam logic       CLR_MODE_RST   = 1'b0;
	localparam logic [7:0] RD_DATA_RST    = 8'h00;

	// cycle counts
	localparam int SYNC_STAGES  = 2;
	localparam int SETTLE_CYCLES = 3;

endpackage

// File: src/cdgc_sync.sv
`timescale 1ns/10ps

// two-flop level synchroniser for the card detect pins
module cdgc_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clock,    // system clock
	input  wire logic             rstn,     // async reset, active low
	input  wire logic [WIDTH-1:0] level_in, // raw pin levels
	output logic      [WIDTH-1:0] level_out // synchronised levels
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] hold_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_hold;

	// first stage feeds only the second stage
	always_comb begin
		nxt_meta = level_in;
		nxt_hold = meta_ff;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= '0;
			hold_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			hold_ff <= nxt_hold;
		end
	end

	assign level_out = hold_ff;

endmodule

// File: src/cdgc_change.sv
`timescale 1ns/10ps

// flags any change of a synchronised level against the previous sample
module cdgc_change #(
	parameter int WIDTH  = 2,
	parameter int SETTLE = cdgc_pkg::SETTLE_CYCLES
) (
	input  wire logic             clock,    // system clock
	input  wire logic             rstn,     // async reset, active low
	input  wire logic [WIDTH-1:0] level_in, // synchronised levels
	output logic                  changed   // one-cycle change pulse
);

	logic [WIDTH-1:0] prev_ff;
	logic [WIDTH-1:0] nxt_prev;
	logic [3:0]       settle_ff;
	logic [3:0]       nxt_settle;
	logic             armed;

	// hold off until the synchroniser carries real pin levels,
	// otherwise an empty socket at reset would look like a removal
	assign armed = (settle_ff == 4'(SETTLE));

	always_comb begin
		nxt_prev   = level_in;
		nxt_settle = armed ? settle_ff : settle_ff + 4'h1;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prev_ff   <= '0;
			settle_ff <= 4'h0;
		end else begin
			prev_ff   <= nxt_prev;
			settle_ff <= nxt_settle;
		end
	end

	assign changed = armed && (level_in != prev_ff);

endmodule

// File: src/cdgc_card_detect_ctrl.sv
// Our own choice: the strobed register port.
`timescale 1ns/10ps

// Functional notes
// - bit 7 reads the present level of the second voltage-sense pin.
// - bit 6 reads the present level of the first voltage-sense pin.
// - with detect enable set, writing 1 to bit 5 sets the detect status flag.
// - with detect enable clear, writing 1 to bit 5 does nothing.
// - bit 5 is write-only, always reads 0 and stays cleared.
// - in write-clear mode, clearing status bit 3 also clears bit 5.
// - wake enable set and a detect change drive the ring wake output low.
// - ring wake stays low until the detect status flag is cleared.
// - with wake enable at 0 detect changes leave ring wake alone.
// - bits 3 and 2 read zero and ignore writes.
// - bit 0 reads zero and ignores writes.
// - bit 1 set resets socket registers on card removal; clear leaves them. The code also does this on any detect change, insertion too.
// - one copy per socket, at local offsets 16h and 56h.
// - flag clear mode 0 clears flags on read, 1 on write of 1.
module cdgc_card_detect_ctrl #(
	parameter int NUM_SOCK = cdgc_pkg::NUM_SOCK
) (
	input  wire logic                          clock,           // 200 MHz clock
	input  wire logic                          rstn,            // async reset, active low
	input  wire logic [cdgc_pkg::ADDR_W-1:0]   addr,            // register address
	input  wire logic [cdgc_pkg::DATA_W-1:0]   wr_data,         // write data
	input  wire logic                          wr_strobe,       // one-cycle write
	input  wire logic                          rd_strobe,       // one-cycle read
	input  wire logic [2*NUM_SOCK-1:0]         detect_pins,     // two detect pins per socket
	input  wire logic [NUM_SOCK-1:0]           sense1_in,       // first voltage-sense pin
	input  wire logic [NUM_SOCK-1:0]           sense2_in,       // second voltage-sense pin
	output logic      [cdgc_pkg::DATA_W-1:0]   rd_data,         // read data, cycle after strobe
	output logic      [NUM_SOCK-1:0]           detect_irq,      // detect change interrupt level
	output logic      [NUM_SOCK-1:0]           regs_reset,      // socket register reset pulse
	output logic                               ring_wake_out_n  // ring wake, active low
);

	// address match for a per-socket register; socket s answers at the
	// base offset plus s strides and every other address misses, so an
	// access between the two images changes nothing
	function automatic logic sock_hit(input logic [11:0] a,
	                                  input logic [11:0] off,
	                                  input int          s);
		logic [11:0] base;
		base = off + cdgc_pkg::SOCK_STRIDE * 12'(s);
		return a == base;
	endfunction

	// global control answers at both socket images
	// one store only; the second image is an alias of the first
	function automatic logic gctl_hit(input logic [11:0] a);
		return (a == cdgc_pkg::GCTL_OFFSET) ||
		       (a == cdgc_pkg::GCTL_OFFSET + cdgc_pkg::SOCK_STRIDE);
	endfunction

	// state shared by both sockets
	logic                         clr_mode_ff;
	logic                         nxt_clr_mode;
	logic [cdgc_pkg::DATA_W-1:0]  rd_data_ff;
	logic [cdgc_pkg::DATA_W-1:0]  nxt_rd_data;
	logic                         ring_n_ff;
	logic                         nxt_ring_n;

	// per-socket state gathered for the read path, the wake pin and the outputs
	logic [NUM_SOCK-1:0] csc_flag_vec;
	logic [NUM_SOCK-1:0] detect_en_vec;
	logic [NUM_SOCK-1:0] wake_en_vec;
	logic [NUM_SOCK-1:0] reg_rst_vec;
	logic [NUM_SOCK-1:0] sense1_vec;
	logic [NUM_SOCK-1:0] sense2_vec;
	logic [NUM_SOCK-1:0] nxt_wake_vec;
	logic [NUM_SOCK-1:0] irq_vec;
	logic [NUM_SOCK-1:0] rst_pulse_vec;

	// global flag clear mode; at 0 a status read clears the flags, at 1
	// only an explicit write of 1 does, so software must keep to one
	// discipline while flags are pending
	always_comb begin
		nxt_clr_mode = clr_mode_ff;
		if (wr_strobe && gctl_hit(addr)) begin
			nxt_clr_mode = wr_data[cdgc_pkg::GCTL_CLR_MODE_BIT];
		end
	end

	// clear mode register, common to both sockets
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			clr_mode_ff <= cdgc_pkg::CLR_MODE_RST;
		end else begin
			clr_mode_ff <= nxt_clr_mode;
		end
	end

	// per-socket slice: each socket owns its detect synchroniser, change
	// detector, status flag, enables, wake latch and sense capture;
	// only the read mux, the clear mode and the wake pin are common,
	// so another socket costs one more copy of this block; the shared
	// logic needs no change except gctl_hit, which decodes only two images
	genvar s;
	generate
		for (s = 0; s < NUM_SOCK; s++) begin : g_sock
			// detect path
			logic [1:0] detect_sync;
			logic       detect_chg;

			// decoded accesses
			logic       wr_cdgc;
			logic       wr_cfg;
			logic       wr_csc;
			logic       rd_csc;

			// flag set and clear terms
			logic       soft_set;
			logic       flag_clr;
			logic       removal;

			// registered state and next values
			logic       csc_flag_ff;
			logic       nxt_csc_flag;
			logic       detect_en_ff;
			logic       nxt_detect_en;
			logic       wake_en_ff;
			logic       nxt_wake_en;
			logic       reg_rst_ff;
			logic       nxt_reg_rst;
			logic       wake_ff;
			logic       nxt_wake;
			logic       irq_ff;
			logic       nxt_irq;
			logic       rst_pulse_ff;
			logic       nxt_rst_pulse;
			// sense pin capture
			logic [1:0] sense_ff;
			logic [1:0] nxt_sense;

			// detect pins are asynchronous to the bus clock; two flops keep
			// metastability out of the change detector
			cdgc_sync #(
				.WIDTH     (2)
			) u_sync (
				.clock     (clock),
				.rstn      (rstn),
				.level_in  (detect_pins[2*s +: 2]),
				.level_out (detect_sync)
			);

			// change pulse, held off for a few cycles after reset
			cdgc_change #(
				.WIDTH     (2),
				.SETTLE    (cdgc_pkg::SETTLE_CYCLES)
			) u_change (
				.clock     (clock),
				.rstn      (rstn),
				.level_in  (detect_sync),
				.changed   (detect_chg)
			);

			// decode of this socket's registers
			// exact match only, no alias inside the socket's window
			always_comb begin
				wr_cdgc = wr_strobe && sock_hit(addr, cdgc_pkg::CDGC_OFFSET, s);
				wr_cfg  = wr_strobe && sock_hit(addr, cdgc_pkg::CSC_CFG_OFFSET, s);
				wr_csc  = wr_strobe && sock_hit(addr, cdgc_pkg::CSC_OFFSET, s);
				rd_csc  = rd_strobe && sock_hit(addr, cdgc_pkg::CSC_OFFSET, s);
			end

			// status flag: detect change or software request sets it
			// the software request is a strobe, not a stored bit, so it
			// has nothing to clear and always reads back as zero
			always_comb begin
				soft_set = wr_cdgc && wr_data[cdgc_pkg::CDGC_SOFT_IRQ_BIT]
				           && detect_en_ff;
				// clear source follows the global mode
				if (clr_mode_ff) begin
					flag_clr = wr_csc && wr_data[cdgc_pkg::CSC_DETECT_BIT];
				end else begin
					flag_clr = rd_csc;
				end
				// a set in the clearing cycle wins so no change is lost
				nxt_csc_flag = detect_chg || soft_set || (csc_flag_ff && !flag_clr);
			end

			// control bits; removal wipes the socket enables
			// the removal enable itself and the status flag survive, so
			// software still sees why the enables went away
			always_comb begin
				removal       = detect_chg && reg_rst_ff;
				nxt_detect_en = detect_en_ff;
				nxt_wake_en   = wake_en_ff;
				nxt_reg_rst   = reg_rst_ff;
				// plain register writes
				if (wr_cfg) begin
					nxt_detect_en = wr_data[cdgc_pkg::CFG_DETECT_EN_BIT];
				end
				if (wr_cdgc) begin
					nxt_wake_en = wr_data[cdgc_pkg::CDGC_WAKE_EN_BIT];
					nxt_reg_rst = wr_data[cdgc_pkg::CDGC_REG_RST_BIT];
				end
				// removal beats a write in the same cycle
				if (removal) begin
					nxt_detect_en = cdgc_pkg::DETECT_EN_RST;
					nxt_wake_en   = cdgc_pkg::WAKE_EN_RST;
				end
				// one pulse per removal event
				nxt_rst_pulse = removal;
			end

			// wake latch holds while the status flag stays set
			// only a real detect change sets it, never the software request,
			// and it falls with the flag so the pin cannot stick low
			always_comb begin
				nxt_wake  = (wake_en_ff && detect_chg) || (wake_ff && nxt_csc_flag);
				nxt_irq   = nxt_csc_flag && nxt_detect_en;
				nxt_sense = {sense2_in[s], sense1_in[s]};
			end

			// register stage for the socket state
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					csc_flag_ff  <= 1'b0;
					detect_en_ff <= cdgc_pkg::DETECT_EN_RST;
					wake_en_ff   <= cdgc_pkg::WAKE_EN_RST;
					reg_rst_ff   <= cdgc_pkg::REG_RST_EN_RST;
					wake_ff      <= 1'b0;
					irq_ff       <= 1'b0;
					rst_pulse_ff <= 1'b0;
					sense_ff     <= 2'h0;
				end else begin
					csc_flag_ff  <= nxt_csc_flag;
					detect_en_ff <= nxt_detect_en;
					wake_en_ff   <= nxt_wake_en;
					reg_rst_ff   <= nxt_reg_rst;
					wake_ff      <= nxt_wake;
					irq_ff       <= nxt_irq;
					rst_pulse_ff <= nxt_rst_pulse;
					sense_ff     <= nxt_sense;
				end
			end

			// export the socket state to the shared logic
			assign csc_flag_vec[s]  = csc_flag_ff;
			assign detect_en_vec[s] = detect_en_ff;
			assign wake_en_vec[s]   = wake_en_ff;
			assign reg_rst_vec[s]   = reg_rst_ff;
			assign sense1_vec[s]    = sense_ff[0];
			assign sense2_vec[s]    = sense_ff[1];
			assign nxt_wake_vec[s]  = nxt_wake;
			assign irq_vec[s]       = irq_ff;
			assign rst_pulse_vec[s] = rst_pulse_ff;
		end
	endgenerate

	// read mux; unlisted bits and unmapped addresses read zero
	// the data register drops back to zero the cycle after a read, so a
	// stale byte never stands on the bus
	always_comb begin
		nxt_rd_data = cdgc_pkg::RD_DATA_RST;
		if (rd_strobe) begin
			for (int i = 0; i < NUM_SOCK; i++) begin
				// sockets never share an address, so one branch fires at most
				if (sock_hit(addr, cdgc_pkg::CDGC_OFFSET, i)) begin
					nxt_rd_data[cdgc_pkg::CDGC_SENSE2_BIT]  = sense2_vec[i];
					nxt_rd_data[cdgc_pkg::CDGC_SENSE1_BIT]  = sense1_vec[i];
					// soft request bit and reserved bits stay zero
					nxt_rd_data[cdgc_pkg::CDGC_SOFT_IRQ_BIT] = 1'b0;
					nxt_rd_data[cdgc_pkg::CDGC_WAKE_EN_BIT] = wake_en_vec[i];
					nxt_rd_data[cdgc_pkg::CDGC_REG_RST_BIT] = reg_rst_vec[i];
				end
				if (sock_hit(addr, cdgc_pkg::CSC_OFFSET, i)) begin
					nxt_rd_data[cdgc_pkg::CSC_DETECT_BIT] = csc_flag_vec[i];
				end
				if (sock_hit(addr, cdgc_pkg::CSC_CFG_OFFSET, i)) begin
					nxt_rd_data[cdgc_pkg::CFG_DETECT_EN_BIT] = detect_en_vec[i];
				end
			end
			if (gctl_hit(addr)) begin
				nxt_rd_data[cdgc_pkg::GCTL_CLR_MODE_BIT] = clr_mode_ff;
			end
		end
	end

	// one shared wake pin; registered from next state so it tracks the latches
	// either socket can hold it low; software finds which from the flags
	always_comb begin
		nxt_ring_n = ~|nxt_wake_vec;
	end

	// registered outputs shared by both sockets
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data_ff <= cdgc_pkg::RD_DATA_RST;
			ring_n_ff  <= 1'b1;
		end else begin
			rd_data_ff <= nxt_rd_data;
			ring_n_ff  <= nxt_ring_n;
		end
	end

	// every output comes straight from a flip-flop
	assign rd_data         = rd_data_ff;
	assign ring_wake_out_n = ring_n_ff;
	assign detect_irq      = irq_vec;
	assign regs_reset      = rst_pulse_vec;

endmodule

// File: test/cdgc_chk.sv
`timescale 1ns/10ps

// watches the register port and socket outputs of the detect control block
module cdgc_chk #(
	parameter int NUM_SOCK = 2
) (
	input logic                  clock,          // system clock
	input logic                  rstn,           // async reset, active low
	input logic [11:0]           addr,           // register address
	input logic [7:0]            wr_data,        // write data
	input logic                  wr_strobe,      // write strobe
	input logic                  rd_strobe,      // read strobe
	input logic [2*NUM_SOCK-1:0] detect_pins,    // card detect pins
	input logic [NUM_SOCK-1:0]   sense1_in,      // first sense pins
	input logic [NUM_SOCK-1:0]   sense2_in,      // second sense pins
	input logic [7:0]            rd_data,        // read data
	input logic [NUM_SOCK-1:0]   detect_irq,     // detect interrupt
	input logic [NUM_SOCK-1:0]   regs_reset,     // register reset pulse
	input logic                  ring_wake_out_n // ring wake, active low
);
	logic [2*NUM_SOCK-1:0] pins_ff;
	logic [5:0]            chg_ff;
	logic                  is_cd;
	logic                  is_csc;

	// decode of the watched offsets
	assign is_cd  = addr == 12'h816 || addr == 12'h856;
	assign is_csc = (rd_strobe || wr_strobe) && (addr == 12'h804 || addr == 12'h844);

	// history of raw pin changes; the design needs three edges to see one
	always_ff @(posedge clock) begin
		pins_ff <= detect_pins;
		chg_ff  <= {chg_ff[4:0], pins_ff != detect_pins};
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	a_rsvd_hi_zero: assert property ($past(rd_strobe && is_cd) |-> rd_data[3:2] == 2'h0)
		else $error("reserved high bits read nonzero");
	a_rsvd_lo_zero: assert property ($past(rd_strobe && is_cd) |-> !rd_data[0])
		else $error("reserved low bit read nonzero");
	a_soft_irq_zero: assert property ($past(rd_strobe && is_cd) |-> !rd_data[5])
		else $error("soft detect bit read nonzero");
	// read data carry the pin level registered the cycle before the strobe edge
	a_sense2_level: assert property ($past(rd_strobe && addr == 12'h816) &&
		$past(rstn, 2) |-> rd_data[7] == $past(sense2_in[0], 2))
		else $error("second sense level misread");
	a_sense1_level: assert property ($past(rd_strobe && addr == 12'h856) &&
		$past(rstn, 2) |-> rd_data[6] == $past(sense1_in[1], 2))
		else $error("first sense level misread");
	a_ring_hold_low: assert property ($rose(ring_wake_out_n) |-> $past(is_csc) || $past(is_csc, 2))
		else $error("ring wake released without a flag clear");
	a_ring_fall_cause: assert property ($fell(ring_wake_out_n) |-> |chg_ff)
		else $error("ring wake fell without a detect change");
	a_reset_pulse_a: assert property (regs_reset[0] |-> |chg_ff ##1 !regs_reset[0])
		else $error("register reset pulse without removal");
	a_unmapped_zero: assert property ($past(rd_strobe) && $past(addr) == 12'h000 |-> !rd_data)
		else $error("unmapped read nonzero");

	cover property ($fell(ring_wake_out_n));
	cover property ($rose(detect_irq[0]));
	cover property (regs_reset[0]);
endmodule

bind cdgc_card_detect_ctrl cdgc_chk #(.NUM_SOCK(NUM_SOCK)) i_chk (
	.clock(clock), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
	.rd_strobe(rd_strobe), .detect_pins(detect_pins), .sense1_in(sense1_in),
	.sense2_in(sense2_in), .rd_data(rd_data), .detect_irq(detect_irq),
	.regs_reset(regs_reset), .ring_wake_out_n(ring_wake_out_n));

// File: test/cdgc_card_model.sv
`timescale 1ns/10ps

// card per socket: detect pins low while seated, sense pins pulled up when empty
module cdgc_card_model (
	input  logic [1:0] seated,      // card present per socket
	input  logic [1:0] vs1,         // card first sense level
	input  logic [1:0] vs2,         // card second sense level
	output logic [3:0] detect_pins, // two detect pins per socket
	output logic [1:0] sense1_in,   // first sense pin
	output logic [1:0] sense2_in    // second sense pin
);
	// both detect pins of a socket follow the card
	assign detect_pins = {{2{~seated[1]}}, {2{~seated[0]}}};
	// empty socket lets the pull-ups win
	assign sense1_in = vs1 | ~seated;
	assign sense2_in = vs2 | ~seated;
endmodule

// File: test/card_detect_general_control_tb_top.sv
`timescale 1ns/10ps

module card_detect_general_control_tb_top;
	logic        clock = 1'h0;
	logic        rstn = 1'h0;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wr_data = 8'h00;
	logic        wr_strobe = 1'h0;
	logic        rd_strobe = 1'h0;
	logic [1:0]  seated = 2'h3;
	logic [1:0]  vs1 = 2'h1;
	logic [1:0]  vs2 = 2'h2;
	logic [3:0]  detect_pins;
	logic [1:0]  sense1_in, sense2_in, detect_irq, regs_reset;
	logic [7:0]  rd_data, got, d;
	logic        ring_wake_out_n;
	int          n_errors = 0;
	int          checks = 0;
	int          seed = 32'hd6e5aa99;
	int          pulses[2] = '{0, 0};
	int          m_wake[2] = '{0, 0};
	int          m_rr[2] = '{0, 0};
	int          s;

	always #2.5 clock = ~clock;

	cdgc_card_model i_card (.seated(seated), .vs1(vs1), .vs2(vs2),
		.detect_pins(detect_pins), .sense1_in(sense1_in), .sense2_in(sense2_in));
	cdgc_card_detect_ctrl i_dut (.clock(clock), .rstn(rstn), .addr(addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.detect_pins(detect_pins), .sense1_in(sense1_in), .sense2_in(sense2_in),
		.rd_data(rd_data), .detect_irq(detect_irq), .regs_reset(regs_reset),
		.ring_wake_out_n(ring_wake_out_n));

	// count register reset pulses per socket
	always @(posedge clock) begin
		if (regs_reset[0] === 1'h1) pulses[0]++;
		if (regs_reset[1] === 1'h1) pulses[1]++;
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wr_data <= v;
		wr_strobe <= 1'h1;
		@(posedge clock);
		wr_strobe <= 1'h0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		addr <= a;
		rd_strobe <= 1'h1;
		@(posedge clock);
		rd_strobe <= 1'h0;
		#1 got = rd_data;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// expected control byte from the bench model
	function automatic logic [7:0] exp_cd(input int k);
		return {vs2[k] | ~seated[k], vs1[k] | ~seated[k], 1'h0, m_wake[k] != 0, 2'h0,
			m_rr[k] != 0, 1'h0};
	endfunction

	task automatic results;
		if (n_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// cut a hang well past the roughly 150 cycles the sequence needs
	initial begin
		#40000;
		n_errors++;
		results;
	end

	initial begin
		repeat (4) @(posedge clock);
		rstn <= 1'h1;
		for (s = 0; s < 2; s++) begin
			rd(s ? 12'h856 : 12'h816);
			chk(got, exp_cd(s));
		end
		rd(12'h000);
		chk(got, 8'h00);
		// random control bytes with fresh sense levels; detect enable is still clear
		repeat (16) begin
			s = $random(seed) & 1;
			d = 8'($random(seed));
			wr(s ? 12'h856 : 12'h816, d);
			// sense levels move on the write's closing edge
			vs1 <= 2'($random(seed));
			vs2 <= 2'($random(seed));
			m_wake[s] = d[4];
			m_rr[s] = d[1];
			rd(s ? 12'h856 : 12'h816);
			chk(got, exp_cd(s));
		end
		wr(12'h856, 8'h10);
		wr(12'h816, 8'h20);
		m_wake = '{0, 1};
		m_rr = '{0, 0};
		idle(3);
		chk(8'(detect_irq), 8'h00);
		rd(12'h804);
		chk(got, 8'h00);
		wr(12'h805, 8'h08);
		wr(12'h816, 8'h20);
		idle(2);
		chk(8'(detect_irq), 8'h01);
		rd(12'h804);
		chk(got, 8'h08);
		idle(2);
		chk(8'(detect_irq), 8'h00);
		// write-back clear mode
		wr(12'h81E, 8'h04);
		wr(12'h816, 8'h20);
		rd(12'h804);
		chk(got, 8'h08);
		idle(2);
		chk(8'(detect_irq), 8'h01);
		wr(12'h804, 8'h08);
		idle(2);
		chk(8'(detect_irq), 8'h00);
		rd(12'h816);
		chk(got, exp_cd(0));
		// removal with wake and register reset enabled
		wr(12'h816, 8'h12);
		@(posedge clock);
		seated <= 2'h2;
		idle(6);
		chk(8'(ring_wake_out_n), 8'h00);
		chk(8'(pulses[0]), 8'h01);
		m_wake[0] = 0;
		m_rr[0] = 1;
		rd(12'h816);
		chk(got, exp_cd(0));
		idle(4);
		chk(8'(ring_wake_out_n), 8'h00);
		wr(12'h804, 8'h08);
		idle(2);
		chk(8'(ring_wake_out_n), 8'h01);
		// insertion with wake now disabled
		@(posedge clock);
		seated <= 2'h3;
		idle(6);
		chk(8'(ring_wake_out_n), 8'h01);
		chk(8'(pulses[0]), 8'h02);
		// second socket: wake on, register reset off, detect enable on
		wr(12'h845, 8'h08);
		@(posedge clock);
		seated <= 2'h1;
		idle(6);
		chk(8'(ring_wake_out_n), 8'h00);
		chk(8'(pulses[1]), 8'h00);
		chk(8'(detect_irq), 8'h02);
		rd(12'h856);
		chk(got, exp_cd(1));
		wr(12'h844, 8'h08);
		idle(2);
		chk(8'(ring_wake_out_n), 8'h01);
		chk(8'(detect_irq), 8'h00);
		results;
	end
endmodule
